// File: fsi_params.svh
// Register offsets, field positions and reset values of the alarm block.
// Assumes nothing; definitions only, shared by package users and modules.
`ifndef FSI_PARAMS_SVH
`define FSI_PARAMS_SVH

// ==========================================================================
// Register offsets (16-bit management address space)
`define FSI_OFS_STATUS_MAIN 16'h000C
`define FSI_OFS_STATUS_INPUTS 16'h000D
`define FSI_OFS_STICKY_MAIN 16'h0011
`define FSI_OFS_STICKY_INPUTS 16'h0012
`define FSI_OFS_MASK_MAIN 16'h0017
`define FSI_OFS_MASK_INPUTS 16'h0018

// ==========================================================================
// Field positions in the main group
`define FSI_BIT_CALIBRATING 0
`define FSI_BIT_REF_PIN_MISSING 1
`define FSI_BIT_SELECTED_REF_MISSING 2
`define FSI_BIT_PLL_UNLOCKED 3
`define FSI_BIT_MGMT_TIMEOUT 5

// Field position and width in the inputs group (input 0 at bit 0)
`define FSI_BIT_INPUT_LSB 0
`define FSI_INPUT_COUNT 4

// ==========================================================================
// Implemented bits per group; all other bits read zero and ignore writes
`define FSI_VALID_MAIN 8'h2F
`define FSI_VALID_INPUTS 8'h0F

// Reset values
`define FSI_RST_STICKY 8'h00
`define FSI_RST_MASK 8'h00
`define FSI_RST_RDATA 8'h00
`define FSI_RST_SYNC 9'h000

`endif

// File: fsi_pkg.sv
// Types shared by the alarm block modules.
// Assumes fsi_params.svh supplies all numeric constants.
package fsi_pkg;

    // ======================================================================
    // One-hot register selection produced by the address decoder
    typedef enum logic [6:0] {
        FSI_SEL_NONE = 7'b000_0001,
        FSI_SEL_STATUS_MAIN = 7'b000_0010,
        FSI_SEL_STATUS_INPUTS = 7'b000_0100,
        FSI_SEL_STICKY_MAIN = 7'b000_1000,
        FSI_SEL_STICKY_INPUTS = 7'b001_0000,
        FSI_SEL_MASK_MAIN = 7'b010_0000,
        FSI_SEL_MASK_INPUTS = 7'b100_0000
    } fsi_reg_sel_t;

    // Group index of a sticky bank
    typedef enum logic [0:0] {
        FSI_GRP_MAIN = 1'b0,
        FSI_GRP_INPUTS = 1'b1
    } fsi_group_t;

endpackage : fsi_pkg

// File: fsi_bank_if.sv
// Carrier between the register front end and one sticky alarm bank.
// Assumes both ends run on the same clock; no timing of its own.
`timescale 1ns/100ps

interface fsi_bank_if;

    // ======================================================================
    // Live status, clear strobe with data, mask, and the bank's answers
    logic [7:0] status;
    logic wr_clear;
    logic [7:0] wr_data;
    logic [7:0] mask;
    logic [7:0] sticky;
    logic pending;

    modport ctrl (
        output status,
        output wr_clear,
        output wr_data,
        output mask,
        input sticky,
        input pending
    );

    modport bank (
        input status,
        input wr_clear,
        input wr_data,
        input mask,
        output sticky,
        output pending
    );

endinterface : fsi_bank_if

// File: fsi_sticky_bank.sv
// One group of eight sticky alarm copies with mask gating.
// Assumes status is already synchronised to ref_clk and wr_clear is a
// single-cycle strobe from the register front end.
`timescale 1ns/100ps
`include "fsi_params.svh"

module fsi_sticky_bank #(
    parameter logic [7:0] VALID_BITS = 8'hFF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Link to the register front end
    fsi_bank_if.bank bank
);

    logic [7:0] sticky_reg;
    logic [7:0] sticky_next;
    logic [7:0] clear_bits;

    // ======================================================================
    // Sticky update
    // Zero written clears, one leaves alone; a high status re-sets the bit
    // in the same cycle, so a clear never beats a live alarm.
    always_comb begin
        clear_bits = bank.wr_clear ? ~bank.wr_data : 8'h00;
        sticky_next = (sticky_reg & ~clear_bits) | bank.status;
        sticky_next = sticky_next & VALID_BITS;
    end

    // Sticky register, cleared by reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sticky_reg <= `FSI_RST_STICKY;
        end else begin
            sticky_reg <= sticky_next;
        end
    end

    // ======================================================================
    // Answers to the front end
    assign bank.sticky = sticky_reg;
    assign bank.pending = |(sticky_reg & ~bank.mask);

endmodule : fsi_sticky_bank

// File: fsi_fault_monitor.sv
// Fault and status monitor: synchronises live alarms, keeps sticky copies,
// exposes status, sticky and mask registers and drives an active-low irq.
// Assumes the management interface decoder delivers single-cycle read and
// write strobes on ref_clk; alarm inputs are asynchronous to ref_clk.
//
// Operation
// - Detect missing signals on inputs and PLL unlock
// - Status readable; unlock also on dedicated pin
// - Each status bit has its own sticky copy
// - Writing zero clears sticky; one leaves it
// - Status bit 0 shows calibration in progress
// - Status bit 1 shows reference pin signal missing
// - Status bit 2 shows selected reference missing
// - Status bit 3 shows PLL unlock
// - Status bit 5 shows management bus timeout
// - Second status register holds per-input missing bits
// - Sticky bits mirror status positions at own offsets
// - Any status change interrupts, each one maskable; here only a status bit that is high sets its sticky and interrupts
// - Mask bit one blocks its sticky from interrupt
// - Interrupt when sticky and not mask is one
// - Interrupt pin low while unmasked sticky set
// - Live high status keeps sticky and interrupt set
`timescale 1ns/100ps
`include "fsi_params.svh"

module fsi_fault_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Live alarm detectors, asynchronous to ref_clk
    input wire logic calibrating,
    input wire logic ref_pin_signal_missing,
    input wire logic selected_ref_missing,
    input wire logic pll_unlocked,
    input wire logic mgmt_bus_timeout,
    input wire logic [3:0] per_input_signal_missing,
    // Register access from the serial management decoder
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    // Alarm pins
    output logic irq_out_n,
    output logic unlock_pin_n
);

    // ======================================================================
    // Address decoding
    // Shared by the read and write paths so both see the same map.
    // Unlisted addresses fall to none: reads give zero, writes vanish.
    function automatic fsi_pkg::fsi_reg_sel_t fsi_decode(
        input logic [15:0] addr
    );
        fsi_pkg::fsi_reg_sel_t sel;
        case (addr)
            `FSI_OFS_STATUS_MAIN: begin
                sel = fsi_pkg::FSI_SEL_STATUS_MAIN;
            end
            `FSI_OFS_STATUS_INPUTS: begin
                sel = fsi_pkg::FSI_SEL_STATUS_INPUTS;
            end
            `FSI_OFS_STICKY_MAIN: begin
                sel = fsi_pkg::FSI_SEL_STICKY_MAIN;
            end
            `FSI_OFS_STICKY_INPUTS: begin
                sel = fsi_pkg::FSI_SEL_STICKY_INPUTS;
            end
            `FSI_OFS_MASK_MAIN: begin
                sel = fsi_pkg::FSI_SEL_MASK_MAIN;
            end
            `FSI_OFS_MASK_INPUTS: begin
                sel = fsi_pkg::FSI_SEL_MASK_INPUTS;
            end
            default: begin
                sel = fsi_pkg::FSI_SEL_NONE;
            end
        endcase
        return sel;
    endfunction : fsi_decode

    // ======================================================================
    // Alarm synchronisers
    // Detectors are analogue and free running; two flops guard against
    // metastability at the cost of two cycles of report latency.
    logic [8:0] alarm_raw;
    logic [8:0] alarm_meta_reg;
    logic [8:0] alarm_sync_reg;

    // Packing of the raw detector outputs
    // Bit order here fixes the status layout below; keep them in step.
    assign alarm_raw = {
        per_input_signal_missing,
        mgmt_bus_timeout,
        pll_unlocked,
        selected_ref_missing,
        ref_pin_signal_missing,
        calibrating
    };

    // Two-stage capture; first stage read only by the second
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alarm_meta_reg <= `FSI_RST_SYNC;
            alarm_sync_reg <= `FSI_RST_SYNC;
        end else begin
            alarm_meta_reg <= alarm_raw;
            alarm_sync_reg <= alarm_meta_reg;
        end
    end

    // ======================================================================
    // Live status registers
    // Combinational views of the synchronised alarms; no extra latency.
    logic [7:0] status_main;
    logic [7:0] status_inputs;

    // Main group layout; bits 4, 6 and 7 stay zero
    always_comb begin
        status_main = 8'h00;
        status_main[`FSI_BIT_CALIBRATING] = alarm_sync_reg[0];
        status_main[`FSI_BIT_REF_PIN_MISSING] = alarm_sync_reg[1];
        status_main[`FSI_BIT_SELECTED_REF_MISSING] = alarm_sync_reg[2];
        status_main[`FSI_BIT_PLL_UNLOCKED] = alarm_sync_reg[3];
        status_main[`FSI_BIT_MGMT_TIMEOUT] = alarm_sync_reg[4];
    end

    // Inputs group: input 0 at bit 0, feedback input at bit 3
    always_comb begin
        status_inputs = 8'h00;
        status_inputs[`FSI_BIT_INPUT_LSB +: `FSI_INPUT_COUNT] =
            alarm_sync_reg[8:5];
    end

    // ======================================================================
    // Write strobes
    // Writes to status match no writable register, unmapped ones decode to none; both are lost;
    // the read decode runs every cycle and is qualified later.
    fsi_pkg::fsi_reg_sel_t wr_sel;
    fsi_pkg::fsi_reg_sel_t rd_sel;

    // Write select only while the strobe is high
    assign wr_sel = reg_wr_en ? fsi_decode(reg_addr) : fsi_pkg::FSI_SEL_NONE;
    // Read select, used under the read strobe
    assign rd_sel = fsi_decode(reg_addr);

    // ======================================================================
    // Mask registers
    // Reset to zero so every alarm can interrupt until software masks it.
    logic [7:0] mask_main_reg;
    logic [7:0] mask_inputs_reg;

    // Main group mask; reserved positions are dropped on write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mask_main_reg <= `FSI_RST_MASK;
        end else if (wr_sel == fsi_pkg::FSI_SEL_MASK_MAIN) begin
            mask_main_reg <= reg_wr_data & `FSI_VALID_MAIN;
        end
    end

    // Inputs group mask; only the four input positions exist
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mask_inputs_reg <= `FSI_RST_MASK;
        end else if (wr_sel == fsi_pkg::FSI_SEL_MASK_INPUTS) begin
            mask_inputs_reg <= reg_wr_data & `FSI_VALID_INPUTS;
        end
    end

    // ======================================================================
    // Sticky banks, one per register group
    // Bank 0 holds the main group, bank 1 the per-input group; both share
    // the write data and differ in status, strobe, mask and valid bits.
    logic [7:0] sticky_main;
    logic [7:0] sticky_inputs;
    logic [1:0] group_pending;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_bank
            fsi_bank_if bank_if ();
            localparam logic [7:0] VALID =
                (g == 0) ? `FSI_VALID_MAIN : `FSI_VALID_INPUTS;

            // Route status, clear strobe and mask of this group
            if (g == 0) begin : gen_main
                assign bank_if.status = status_main;
                assign bank_if.wr_clear =
                    (wr_sel == fsi_pkg::FSI_SEL_STICKY_MAIN);
                assign bank_if.mask = mask_main_reg;
                assign sticky_main = bank_if.sticky;
            end else begin : gen_inputs
                assign bank_if.status = status_inputs;
                assign bank_if.wr_clear =
                    (wr_sel == fsi_pkg::FSI_SEL_STICKY_INPUTS);
                assign bank_if.mask = mask_inputs_reg;
                assign sticky_inputs = bank_if.sticky;
            end
            assign bank_if.wr_data = reg_wr_data;
            assign group_pending[g] = bank_if.pending;

            fsi_sticky_bank #(
                .VALID_BITS(VALID)
            ) u_bank (
                .ref_clk(ref_clk),
                .reset(reset),
                .bank(bank_if.bank)
            );
        end
    endgenerate

    // ======================================================================
    // Read path
    // Data is registered and shown one cycle after the strobe; unmapped
    // addresses answer zero so software never sees stale data.
    // Status reads show the synchronised level, two edges behind the pin.
    logic [7:0] rd_data_next;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;

    always_comb begin
        case (rd_sel)
            fsi_pkg::FSI_SEL_STATUS_MAIN: begin
                rd_data_next = status_main;
            end
            fsi_pkg::FSI_SEL_STATUS_INPUTS: begin
                rd_data_next = status_inputs;
            end
            fsi_pkg::FSI_SEL_STICKY_MAIN: begin
                rd_data_next = sticky_main;
            end
            fsi_pkg::FSI_SEL_STICKY_INPUTS: begin
                rd_data_next = sticky_inputs;
            end
            fsi_pkg::FSI_SEL_MASK_MAIN: begin
                rd_data_next = mask_main_reg;
            end
            fsi_pkg::FSI_SEL_MASK_INPUTS: begin
                rd_data_next = mask_inputs_reg;
            end
            default: begin
                rd_data_next = 8'h00;
            end
        endcase
    end

    // Valid pulse, one cycle after every read strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_valid_reg <= 1'h0;
        end else begin
            rd_valid_reg <= reg_rd_en;
        end
    end

    // Read data holds between reads so a slow host can still pick it up
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data_reg <= `FSI_RST_RDATA;
        end else if (reg_rd_en) begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign reg_rd_valid = rd_valid_reg;

    // ======================================================================
    // Alarm pins
    // Registered so the pins never glitch on decode paths; the pin can
    // still move while reset is applied, which the host must tolerate.
    logic irq_n_reg;
    logic unlock_n_reg;

    // Any unmasked sticky bit in either group pulls the pin
    logic irq_any;

    assign irq_any = |group_pending;

    // Interrupt pin, released during reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_n_reg <= 1'h1;
        end else begin
            irq_n_reg <= ~irq_any;
        end
    end

    // Unlock pin follows the synchronised status, not the raw detector,
    // so it never shows a level that the status register does not.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            unlock_n_reg <= 1'h1;
        end else begin
            unlock_n_reg <= ~status_main[`FSI_BIT_PLL_UNLOCKED];
        end
    end

    assign irq_out_n = irq_n_reg;
    assign unlock_pin_n = unlock_n_reg;

endmodule : fsi_fault_monitor

// File: fsi_host_model.sv
// Host model: drives the register strobes and watches the irq pin.
// Assumes ref_clk and reset come from the bench.
`timescale 1ns/100ps
module fsi_host_model (
    // Clock, reset and device pins
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic irq_out_n,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid,
    // Register strobes
    output logic [15:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en
);
    // Pin may toggle in reset, so it is trusted only outside it
    logic irq_seen;
    assign irq_seen = !irq_out_n && !reset;
    initial begin
        reg_addr = 16'h0000;
        reg_wr_en = 1'h0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'h0;
    end
    // One-cycle write; zero bits clear sticky copies
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'h1;
        @(posedge ref_clk);
        reg_wr_en <= 1'h0;
    endtask : wr
    // One-cycle read, then a bounded wait for the valid pulse
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        int n;
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd_en <= 1'h1;
        @(posedge ref_clk);
        reg_rd_en <= 1'h0;
        n = 0;
        #1;
        while (reg_rd_valid !== 1'h1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        d = (reg_rd_valid === 1'h1) ? reg_rd_data : 8'hxx;
    endtask : rd
endmodule : fsi_host_model

// File: fsi_chk_monitor.sv
// Checker on the ports of the alarm block top.
// Assumes one clock; alarm inputs settle through two sync stages.
`timescale 1ns/100ps
module fsi_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Alarms
    input wire logic calibrating,
    input wire logic ref_pin_signal_missing,
    input wire logic selected_ref_missing,
    input wire logic pll_unlocked,
    input wire logic mgmt_bus_timeout,
    input wire logic [3:0] per_input_signal_missing,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid,
    // Pins
    input wire logic irq_out_n,
    input wire logic unlock_pin_n
);
    logic [2:0] live_cnt;
    logic [2:0] stab;
    logic [8:0] alm_q;
    logic [8:0] alm;
    logic [7:0] msk_m;
    logic [7:0] msk_i;
    logic [7:0] vmask;
    logic live;
    logic mapped;
    // ==================================================================
    // Helpers: settle counters and a shadow of the masks
    assign alm = {per_input_signal_missing, mgmt_bus_timeout,
        pll_unlocked, selected_ref_missing, ref_pin_signal_missing,
        calibrating};
    assign live = (live_cnt == 3'h7);
    assign mapped = reg_addr inside {16'h000C, 16'h000D, 16'h0011,
        16'h0012, 16'h0017, 16'h0018};
    assign vmask = (reg_addr inside {16'h000D, 16'h0012, 16'h0018}) ?
        8'h0F : 8'h2F;
    always_ff @(posedge ref_clk) begin
        live_cnt <= reset ? 3'h0 : (live ? live_cnt : live_cnt + 3'h1);
        alm_q <= alm;
        stab <= (alm != alm_q) ? 3'h0 : ((stab == 3'h7) ? stab : stab + 3'h1);
    end
    // Shadow masks; reserved positions never stick
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            msk_m <= 8'h00;
            msk_i <= 8'h00;
        end else if (reg_wr_en && reg_addr == 16'h0017) begin
            msk_m <= reg_wr_data & 8'h2F;
        end else if (reg_wr_en && reg_addr == 16'h0018) begin
            msk_i <= reg_wr_data & 8'h0F;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ==================================================================
    // Properties
    property p_rd_valid;
        reg_rd_en |=> reg_rd_valid;
    endproperty
    property p_unlock;
        live |-> unlock_pin_n == !$past(pll_unlocked, 3);
    endproperty
    property p_stat_main;
        reg_rd_en && reg_addr == 16'h000C && stab >= 3'h3 && live |=>
            reg_rd_data == {2'h0, $past(alm[4], 3), 1'h0, $past(alm[3:0], 3)};
    endproperty
    property p_stat_inp;
        reg_rd_en && reg_addr == 16'h000D && stab >= 3'h3 && live |=>
            reg_rd_data == {4'h0, $past(alm[8:5], 3)};
    endproperty
    property p_unmapped;
        reg_rd_en && !mapped |=> reg_rd_data == 8'h00;
    endproperty
    property p_reserved;
        reg_rd_en && mapped |=> (reg_rd_data & ~$past(vmask)) == 8'h00;
    endproperty
    property p_irq_rst;
        $past(reset) |-> irq_out_n && unlock_pin_n;
    endproperty
    property p_alarm_irq;
        (live && pll_unlocked && !msk_m[3])[*5] |-> !irq_out_n;
    endproperty
    property p_mask_blk;
        (msk_m == 8'h2F && msk_i == 8'h0F)[*2] |-> irq_out_n;
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("read strobe without valid");
    a_unlock: assert property (p_unlock)
        else $error("unlock pin wrong");
    a_stat_main: assert property (p_stat_main)
        else $error("main status wrong");
    a_stat_inp: assert property (p_stat_inp)
        else $error("input status wrong");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");
    a_irq_rst: assert property (p_irq_rst)
        else $error("pins active after reset");
    a_alarm_irq: assert property (p_alarm_irq)
        else $error("unmasked alarm gave no irq");
    a_mask_blk: assert property (p_mask_blk)
        else $error("masked irq asserted");
    c_read: cover property (reg_rd_valid);
    c_irq: cover property ($fell(irq_out_n));
    c_unlock: cover property ($fell(unlock_pin_n));
endmodule : fsi_chk
bind fsi_fault_monitor fsi_chk chk_u (.ref_clk(ref_clk), .reset(reset),
    .calibrating(calibrating),
    .ref_pin_signal_missing(ref_pin_signal_missing),
    .selected_ref_missing(selected_ref_missing),
    .pll_unlocked(pll_unlocked), .mgmt_bus_timeout(mgmt_bus_timeout),
    .per_input_signal_missing(per_input_signal_missing),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .irq_out_n(irq_out_n), .unlock_pin_n(unlock_pin_n));

// File: fsi_tb.sv
// Bench: host model drives registers, bench drives alarm levels.
// Assumes the register map of the alarm block top.
`timescale 1ns/100ps
module tb;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic [8:0] alm = 9'h000;
    logic [15:0] reg_addr;
    logic reg_wr_en, reg_rd_en, reg_rd_valid, irq_out_n, unlock_pin_n;
    logic [7:0] reg_wr_data, reg_rd_data, d;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    // ==================================================================
    // Clock, device and host
    always #5 ref_clk = ~ref_clk;
    fsi_fault_monitor dut_u (.ref_clk(ref_clk), .reset(reset),
        .calibrating(alm[0]), .ref_pin_signal_missing(alm[1]),
        .selected_ref_missing(alm[2]), .pll_unlocked(alm[3]),
        .mgmt_bus_timeout(alm[4]), .per_input_signal_missing(alm[8:5]),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .irq_out_n(irq_out_n), .unlock_pin_n(unlock_pin_n));
    fsi_host_model host_u (.ref_clk(ref_clk), .reset(reset),
        .irq_out_n(irq_out_n), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en));
    // ==================================================================
    // Expected register images of an alarm vector
    function automatic logic [7:0] xm(input logic [8:0] a);
        return {2'h0, a[4], 1'h0, a[3:0]};
    endfunction : xm
    function automatic logic [7:0] xi(input logic [8:0] a);
        return {4'h0, a[8:5]};
    endfunction : xi
    task automatic chk(input string nm, input logic [7:0] s, e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        host_u.rd(a, d);
        chk($sformatf("reg %h", a), d, e);
    endtask : rchk
    // Waits land past the edge so pins are settled
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wt
    task automatic conclude;
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // Hang guard, far above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    // ==================================================================
    // Sequence
    initial begin
        logic [8:0] av;
        repeat (12) @(posedge ref_clk);
        reset <= 1'h0;
        wt(4);
        rchk(16'h0011, 8'h00);
        rchk(16'h0018, 8'h00);
        chk("irq", {7'h00, irq_out_n}, 8'h01);
        // Each alarm alone: status, sticky, clear rules
        for (int k = 0; k < 9; k++) begin
            av = 9'h001 << k;
            @(posedge ref_clk) alm <= av;
            wt(6);
            rchk(16'h000C, xm(av));
            rchk(16'h000D, xi(av));
            chk("unlock", {7'h00, unlock_pin_n}, {7'h00, !av[3]});
            chk("irq", {7'h00, irq_out_n}, 8'h00);
            host_u.wr(16'h0011, 8'h00);
            host_u.wr(16'h0012, 8'h00);
            rchk(16'h0011, xm(av));
            rchk(16'h0012, xi(av));
            @(posedge ref_clk) alm <= 9'h000;
            wt(6);
            rchk(16'h000C, 8'h00);
            rchk(16'h0011, xm(av));
            host_u.wr(16'h0011, 8'hFF);
            host_u.wr(16'h0012, 8'hFF);
            rchk(16'h0012, xi(av));
            host_u.wr(16'h0011, 8'h00);
            host_u.wr(16'h0012, 8'h00);
            wt(2);
            chk("irq", {7'h00, irq_out_n}, 8'h01);
            rchk(16'h0011, 8'h00);
        end
        // Masks, reserved bits, read-only and unmapped places
        host_u.wr(16'h0017, 8'hFF);
        host_u.wr(16'h0018, 8'hFF);
        rchk(16'h0017, 8'h2F);
        rchk(16'h0018, 8'h0F);
        @(posedge ref_clk) alm <= 9'h1FF;
        wt(6);
        chk("irq", {7'h00, irq_out_n}, 8'h01);
        host_u.wr(16'h0018, 8'h0E);
        wt(2);
        chk("irq", {7'h00, irq_out_n}, 8'h00);
        @(posedge ref_clk) alm <= 9'h000;
        wt(6);
        host_u.wr(16'h0012, 8'h00);
        wt(2);
        chk("irq", {7'h00, irq_out_n}, 8'h01);
        host_u.wr(16'h000C, 8'hFF);
        rchk(16'h000C, 8'h00);
        rchk(16'h0013, 8'h00);
        rchk(16'h0011, 8'h2F);
        host_u.wr(16'h0017, 8'h00);
        wt(2);
        chk("irq seen", {7'h00, host_u.irq_seen}, 8'h01);
        // Reset in mid-run wipes sticky and mask; pin is ignored meanwhile
        @(posedge ref_clk) reset <= 1'h1;
        wt(3);
        chk("irq seen", {7'h00, host_u.irq_seen}, 8'h00);
        @(posedge ref_clk) reset <= 1'h0;
        wt(3);
        rchk(16'h0011, 8'h00);
        rchk(16'h0017, 8'h00);
        rchk(16'h0018, 8'h00);
        conclude();
    end
endmodule : tb
